// [src/tape_unit_panel_load_control.sv]
// Contract
// - power toggle ignored without mains present; power lamp lit while powered.
// - write-protect lamp lit when no ring once a load has started, held until unload completes.
// - load press with no tape starts load to start marker; lamp lights.
// - load/rewind lamp also lit at or past end marker.
// - load press with tape loaded rewinds to start marker; lamp lights.
// - online press after load puts unit online; other operations need reset.
// - reset press stops motion only in threading, slow rewind and rewind-unload's fast rewind; takes unit offline.
// - reset during load-press fast rewind slows it; second reset stops motion.
// - reset lamp flashes while a machine check exists.
// - rewind-unload press at start marker unloads onto file reel.
// - rewind-unload away from marker rewinds fast, then unloads at normal speed.
// - rewind-unload lamp follows controller select; control works only offline.
// - density press toggles phase-encoded/group-coded, exactly one lamp lit.
// - window lowers only with no load active; closes when threaded tape reaches start marker.
// - threading timeout about 10 s: rewind and retry once, then fail flashing.
// - after threading, forward to marker, close window, vacuum to columns.
// - forward search 1.5 s, then backward; not found unloads and flashes reset.
// - marker found ends load: lamp lit, ready, online press accepted.
`timescale 1ns/1ps
`default_nettype none
module tape_unit_panel_load_control
  import tape_panel_pkg::*;
#(
  parameter int unsigned THREAD_CYC   = THREAD_TIMEOUT_CYC,
  parameter int unsigned SEARCH_CYC   = START_SEARCH_CYC,
  parameter int unsigned FLASH_CYC    = FLASH_HALF_CYC,
  parameter int unsigned BOUNCE_CYC   = DEBOUNCE_CYC
) (
  input  wire logic                    clock_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [NUM_CONTROLS-1:0] touch_i,
  input  wire sensors_s                sensors_i,
  input  wire logic                    formatter_controller_select_i,
  input  wire logic [1:0]              reg_addr_i,
  input  wire logic [31:0]             reg_wdata_i,
  input  wire logic                    reg_write_i,
  input  wire logic                    reg_read_i,
  output logic [31:0]                  reg_rdata_o,
  output logic                         irq_o,
  output motion_s                      motion_o,
  output lamps_s                       lamps_o,
  output logic                         unit_power_o,
  output logic                         window_lower_o,
  output logic                         window_close_o
);
  localparam int unsigned TW = $clog2(THREAD_CYC + 1);
  localparam int unsigned SW = $clog2(SEARCH_CYC + 1);
  localparam int unsigned FW = $clog2(FLASH_CYC + 1);

  initial begin
    if (THREAD_CYC < 1 || SEARCH_CYC < 1 || FLASH_CYC < 1) $error("counts must be at least one");
  end

  logic [NUM_CONTROLS-1:0] press;
  sensors_s                sens_a;
  sensors_s                sens;
  logic                    sel_a;
  logic                    sel;
  load_state_e             state;
  logic                    retried;
  logic [TW-1:0]           thread_count;
  logic [SW-1:0]           search_count;
  logic [FW-1:0]           flash_count;
  logic                    flash;
  logic                    online;
  logic                    powered;
  logic                    protect;
  logic                    density_ge;
  logic [INT_WIDTH-1:0]    int_status;
  logic [INT_WIDTH-1:0]    int_enable;
  logic [INT_WIDTH-1:0]    events;
  logic                    mc_prev;

  for (genvar g = 0; g < NUM_CONTROLS; g++) begin : g_touch
    touch_debounce #(
      .STABLE_CYC (BOUNCE_CYC)
    ) u_touch (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .raw_i     (touch_i[g]),
      .press_o   (press[g])
    );
  end

  // sensors are asynchronous to the clock
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sens_a <= '0;
      sens   <= '0;
      sel_a  <= 1'b0;
      sel    <= 1'b0;
    end else begin
      sens_a <= sensors_i;
      sens   <= sens_a;
      sel_a  <= formatter_controller_select_i;
      sel    <= sel_a;
    end
  end

  function automatic logic is_busy(input load_state_e s);
    return (s != IDLE) && (s != READY) && (s != FAILED);
  endfunction

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      powered <= 1'b0;
    end else if (press[CTL_POWER] && sens.mains_present) begin
      powered <= !powered;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      protect <= 1'b0;
    end else if (state == UNLOADING && sens.unload_done) begin
      protect <= 1'b0;
    end else if (!sens.ring_present && state != IDLE) begin
      protect <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      density_ge <= 1'b0;
    end else if (press[CTL_DENSITY] && powered) begin
      density_ge <= !density_ge;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      online <= 1'b0;
    end else if (press[CTL_RESET]) begin
      online <= 1'b0;
    end else if (press[CTL_ONLINE] && state == READY) begin
      online <= 1'b1;
    end
  end

  // main load / rewind / unload sequencer
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !powered) begin
      state        <= IDLE;
      retried      <= 1'b0;
      thread_count <= '0;
      search_count <= '0;
    end else begin
      case (state)
        IDLE: begin
          if (press[CTL_LOAD_REWIND]) begin
            state        <= THREADING;
            retried      <= 1'b0;
            thread_count <= '0;
          end
        end
        THREADING: begin
          if (press[CTL_RESET]) begin
            state <= IDLE;
          end else if (sens.on_machine_reel) begin
            state <= TO_START;
          end else if (thread_count == TW'(THREAD_CYC - 1)) begin
            state <= THREAD_REWIND;
          end else begin
            thread_count <= thread_count + TW'(1);
          end
        end
        THREAD_REWIND: begin
          // leader back on the file reel when the transport reports it
          if (sens.unload_done) begin
            thread_count <= '0;
            retried      <= 1'b1;
            state        <= retried ? FAILED : THREADING;
          end
        end
        TO_START: begin
          if (sens.tape_start_marker) begin
            state <= COLUMNS;
          end
        end
        COLUMNS: begin
          if (sens.columns_loaded) begin
            state        <= SEARCH_FWD;
            search_count <= '0;
          end
        end
        SEARCH_FWD: begin
          if (sens.tape_start_marker) begin
            state        <= READY;
            search_count <= '0;
          end else if (search_count == SW'(SEARCH_CYC - 1)) begin
            state        <= SEARCH_BACK;
            search_count <= '0;
          end else begin
            search_count <= search_count + SW'(1);
          end
        end
        SEARCH_BACK: begin
          if (sens.tape_start_marker) begin
            state        <= READY;
            search_count <= '0;
          end else if (search_count == SW'(SEARCH_CYC - 1)) begin
            state <= UNLOADING;
            retried <= 1'b1;
          end else begin
            search_count <= search_count + SW'(1);
          end
        end
        READY: begin
          if (!online && press[CTL_LOAD_REWIND] && !sens.tape_start_marker) begin
            state <= REWIND_FAST;
          end else if (!online && press[CTL_REWIND_UNLOAD]) begin
            state <= sens.tape_start_marker ? UNLOADING : UNLOAD_FAST;
          end
        end
        REWIND_FAST: begin
          if (press[CTL_RESET]) begin
            state <= REWIND_SLOW;
          end else if (sens.tape_start_marker) begin
            state <= READY;
          end
        end
        REWIND_SLOW: begin
          if (press[CTL_RESET] || sens.tape_start_marker) begin
            state <= READY;
          end
        end
        UNLOAD_FAST: begin
          if (sens.tape_start_marker) begin
            state <= UNLOADING;
          end else if (press[CTL_RESET]) begin
            state <= READY;
          end
        end
        UNLOADING: begin
          if (sens.unload_done) begin
            state <= (search_count == SW'(SEARCH_CYC - 1)) ? FAILED : IDLE;
          end
        end
        FAILED: begin
          if (press[CTL_RESET]) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      flash_count <= '0;
      flash       <= 1'b0;
    end else if (flash_count == FW'(FLASH_CYC - 1)) begin
      flash_count <= '0;
      flash       <= !flash;
    end else begin
      flash_count <= flash_count + FW'(1);
    end
  end

  always_comb begin
    events                    = '0;
    events[EVT_LOAD_DONE]     = (state == SEARCH_FWD || state == SEARCH_BACK)
                                && sens.tape_start_marker;
    events[EVT_THREAD_FAIL]   = state == THREAD_REWIND && sens.unload_done && retried;
    events[EVT_START_FAIL]    = state == SEARCH_BACK && search_count == SW'(SEARCH_CYC - 1)
                                && !sens.tape_start_marker;
    events[EVT_UNLOAD_DONE]   = state == UNLOADING && sens.unload_done;
    events[EVT_MACHINE_CHECK] = sens.machine_check && !mc_prev;
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      int_status <= '0;
      int_enable <= '0;
      mc_prev    <= 1'b0;
    end else begin
      mc_prev <= sens.machine_check;
      if (reg_write_i && reg_addr_i == ADDR_ENABLE) begin
        int_enable <= reg_wdata_i[INT_WIDTH-1:0];
      end
      if (reg_write_i && reg_addr_i == ADDR_CLEAR) begin
        int_status <= (int_status & ~reg_wdata_i[INT_WIDTH-1:0]) | events;
      end else begin
        int_status <= int_status | events;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_read_i) begin
      case (reg_addr_i)
        ADDR_STATUS: reg_rdata_o <= 32'(int_status);
        ADDR_ENABLE: reg_rdata_o <= 32'(int_enable);
        ADDR_STATE:  reg_rdata_o <= {16'h0000, 8'(state), 5'h00, online, density_ge, powered};
        default:     reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      irq_o          <= 1'b0;
      motion_o       <= '0;
      lamps_o        <= '0;
      unit_power_o   <= 1'b0;
      window_lower_o <= 1'b0;
      window_close_o <= 1'b0;
    end else begin
      irq_o                 <= |(int_status & int_enable);
      unit_power_o          <= powered;
      motion_o.fwd          <= state == TO_START || state == SEARCH_FWD;
      motion_o.rev          <= state == THREAD_REWIND || state == SEARCH_BACK
                               || state == REWIND_FAST || state == REWIND_SLOW
                               || state == UNLOAD_FAST;
      motion_o.high_speed   <= state == REWIND_FAST || state == UNLOAD_FAST;
      motion_o.thread       <= state == THREADING;
      motion_o.column_vacuum <= state == COLUMNS || state == SEARCH_FWD
                                || state == SEARCH_BACK || state == READY
                                || state == REWIND_FAST || state == REWIND_SLOW
                                || state == UNLOAD_FAST;
      motion_o.unload       <= state == UNLOADING;
      lamps_o.power         <= powered;
      lamps_o.write_protect <= protect;
      lamps_o.load_rewind   <= (state == READY && sens.tape_start_marker)
                               || state == REWIND_FAST || state == REWIND_SLOW
                               || is_busy(state) && state != UNLOAD_FAST && state != UNLOADING
                               || sens.tape_end_marker;
      lamps_o.online        <= online;
      lamps_o.reset         <= (state == FAILED || sens.machine_check) && flash;
      lamps_o.rewind_unload <= sel;
      lamps_o.phase_encoded_density   <= !density_ge;
      lamps_o.group_density_indicator <= density_ge;
      window_lower_o        <= press[CTL_WINDOW] && state == IDLE;
      window_close_o        <= state == TO_START && sens.tape_start_marker;
    end
  end
endmodule
`default_nettype wire

// [src/tape_panel_pkg.sv]
package tape_panel_pkg;

  localparam int unsigned CLOCK_HZ            = 125_000_000;
  localparam int unsigned THREAD_TIMEOUT_MS   = 10_000;
  localparam int unsigned START_SEARCH_MS     = 1_500;
  localparam int unsigned THREAD_TIMEOUT_CYC  = THREAD_TIMEOUT_MS * (CLOCK_HZ / 1000);
  localparam int unsigned START_SEARCH_CYC    = START_SEARCH_MS * (CLOCK_HZ / 1000);
  localparam int unsigned DEBOUNCE_US         = 10_000;
  localparam int unsigned DEBOUNCE_CYC        = DEBOUNCE_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned FLASH_HALF_MS       = 250;
  localparam int unsigned FLASH_HALF_CYC      = FLASH_HALF_MS * (CLOCK_HZ / 1000);

  localparam int unsigned NUM_CONTROLS        = 7;
  localparam int unsigned CTL_POWER           = 0;
  localparam int unsigned CTL_LOAD_REWIND     = 1;
  localparam int unsigned CTL_ONLINE          = 2;
  localparam int unsigned CTL_RESET           = 3;
  localparam int unsigned CTL_REWIND_UNLOAD   = 4;
  localparam int unsigned CTL_DENSITY         = 5;
  localparam int unsigned CTL_WINDOW          = 6;

  localparam int unsigned INT_WIDTH           = 5;
  localparam int unsigned EVT_LOAD_DONE       = 0;
  localparam int unsigned EVT_THREAD_FAIL     = 1;
  localparam int unsigned EVT_START_FAIL      = 2;
  localparam int unsigned EVT_UNLOAD_DONE     = 3;
  localparam int unsigned EVT_MACHINE_CHECK   = 4;

  localparam logic [1:0] ADDR_STATUS          = 2'h0;
  localparam logic [1:0] ADDR_CLEAR           = 2'h1;
  localparam logic [1:0] ADDR_ENABLE          = 2'h2;
  localparam logic [1:0] ADDR_STATE           = 2'h3;

  typedef enum {
    IDLE, THREADING, THREAD_REWIND, TO_START, COLUMNS, SEARCH_FWD,
    SEARCH_BACK, READY, REWIND_FAST, REWIND_SLOW, UNLOAD_FAST,
    UNLOAD_SLOW, UNLOADING, FAILED
  } load_state_e;

  // sensors from the transport mechanics
  typedef struct packed {
    logic mains_present;
    logic ring_present;
    logic tape_start_marker;
    logic tape_end_marker;
    logic on_machine_reel;
    logic columns_loaded;
    logic unload_done;
    logic machine_check;
  } sensors_s;

  // motion commands toward the transport
  typedef struct packed {
    logic fwd;
    logic rev;
    logic high_speed;
    logic thread;
    logic column_vacuum;
    logic unload;
  } motion_s;

  // panel indicator lamps
  typedef struct packed {
    logic power;
    logic write_protect;
    logic load_rewind;
    logic online;
    logic reset;
    logic rewind_unload;
    logic phase_encoded_density;
    logic group_density_indicator;
  } lamps_s;

endpackage

// [src/touch_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
module touch_debounce
  import tape_panel_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEBOUNCE_CYC
) (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic raw_i,
  output logic      press_o
);
  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  initial begin
    if (STABLE_CYC < 1) $error("debounce count must be at least one");
  end

  logic          sync_a;
  logic          sync_b;
  logic          level;
  logic [CW-1:0] count;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= raw_i;
      sync_b <= sync_a;
    end
  end

  // level only moves after the input has held for the whole window
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      count <= '0;
      level <= 1'b0;
    end else if (sync_b == level) begin
      count <= '0;
    end else if (count == CW'(STABLE_CYC - 1)) begin
      count <= '0;
      level <= sync_b;
    end else begin
      count <= count + CW'(1);
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      press_o <= 1'b0;
    end else begin
      press_o <= (sync_b != level) && (count == CW'(STABLE_CYC - 1)) && sync_b;
    end
  end
endmodule
`default_nettype wire

// [tb/tape_panel_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module tape_panel_assertions
  import tape_panel_pkg::*;
#(
  parameter int unsigned THREAD_CYC = THREAD_TIMEOUT_CYC
) (
  input  wire logic     clock_i,
  input  wire logic     sys_rst_i,
  input  wire sensors_s sensors_i,
  input  wire logic     formatter_controller_select_i,
  input  wire motion_s  motion_o,
  input  wire lamps_s   lamps_o,
  input  wire logic     unit_power_o,
  input  wire logic     window_lower_o,
  input  wire logic     window_close_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  int unsigned thr_cnt;
  // counts one threading attempt; reset when the thread drive drops
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || !motion_o.thread) thr_cnt <= 0;
    else thr_cnt <= thr_cnt + 1;
  end
  sequence s_sel_held;
    (formatter_controller_select_i && unit_power_o) [*6];
  endsequence
  sequence s_chk_held;
    (sensors_i.machine_check && unit_power_o) [*8];
  endsequence
  property p_power_lamp;
    lamps_o.power == unit_power_o;
  endproperty
  a_power_lamp: assert property (p_power_lamp) else $error("power lamp off state");
  property p_power_mains;
    $rose(unit_power_o) |-> $past(sensors_i.mains_present, 4);
  endproperty
  a_power_mains: assert property (p_power_mains) else $error("power without mains");
  property p_onehot;
    unit_power_o |-> (lamps_o.phase_encoded_density ^ lamps_o.group_density_indicator);
  endproperty
  a_onehot: assert property (p_onehot) else $error("density lamps not one hot");
  property p_select;
    s_sel_held |-> lamps_o.rewind_unload;
  endproperty
  a_select: assert property (p_select) else $error("select lamp dark");
  property p_flash;
    s_chk_held |-> ##[0:3] $changed(lamps_o.reset);
  endproperty
  a_flash: assert property (p_flash) else $error("reset lamp not flashing");
  property p_online_ready;
    $rose(lamps_o.online) |-> lamps_o.load_rewind;
  endproperty
  a_online_ready: assert property (p_online_ready) else $error("online before ready");
  property p_close_vac;
    window_close_o |-> ##[0:3] motion_o.column_vacuum;
  endproperty
  a_close_vac: assert property (p_close_vac) else $error("close without vacuum");
  property p_lower_idle;
    window_lower_o |-> motion_o == 6'h00;
  endproperty
  a_lower_idle: assert property (p_lower_idle) else $error("window lowered in load");
  property p_thread_limit;
    thr_cnt <= THREAD_CYC + 4;
  endproperty
  a_thread_limit: assert property (p_thread_limit) else $error("threading overran");
endmodule
bind tape_unit_panel_load_control tape_panel_assertions #(.THREAD_CYC(THREAD_CYC))
  tape_panel_assertions_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sensors_i(sensors_i),
  .formatter_controller_select_i(formatter_controller_select_i), .motion_o(motion_o),
  .lamps_o(lamps_o), .unit_power_o(unit_power_o), .window_lower_o(window_lower_o),
  .window_close_o(window_close_o));
`default_nettype wire

// [tb/tape_transport_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tape_transport_model
  import tape_panel_pkg::*;
(
  input  wire logic     clock_i,
  input  wire logic     sys_rst_i,
  input  wire motion_s  motion_i,
  input  wire logic     mains_i,
  input  wire logic     ring_i,
  input  wire logic     check_i,
  input  wire logic     thread_ok_i,
  input  wire logic     wind_i,
  output sensors_s      sensors_o
);
  logic [5:0] pos;
  logic [1:0] pre;
  logic [3:0] thr;
  logic [2:0] vac;
  logic       reel;
  logic       cols;
  logic       done;
  // tape moves once per four cycles so marker outlasts input sync delay
  assign done = (pos == 6'h00) && (motion_i.rev || motion_i.unload);
  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      {pos, pre, thr, vac, reel, cols} <= '0;
    end else begin
      pre <= pre + 2'h1;
      thr <= motion_i.thread ? ((thr == 4'hF) ? thr : thr + 4'h1) : 4'h0;
      vac <= motion_i.column_vacuum ? ((vac == 3'h7) ? vac : vac + 3'h1) : 3'h0;
      if (wind_i) pos <= 6'h30;
      else if (pre == 2'h3 && motion_i.fwd && pos != 6'h3F) pos <= pos + 6'h1;
      else if (pre == 2'h3 && (motion_i.rev || motion_i.unload) && pos != 6'h00) pos <= pos - 6'h1;
      if (done) reel <= 1'b0;
      else if (thr == 4'h5 && thread_ok_i) reel <= 1'b1;
      if (done) cols <= 1'b0;
      else if (vac == 3'h3) cols <= 1'b1;
    end
  end
  assign sensors_o = '{mains_present: mains_i, ring_present: ring_i,
    tape_start_marker: (pos >= 6'h08 && pos <= 6'h0A), tape_end_marker: (pos >= 6'h28),
    on_machine_reel: reel, columns_loaded: cols, unload_done: done, machine_check: check_i};
endmodule
`default_nettype wire

// [tb/tape_unit_panel_load_control_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tape_unit_panel_load_control_tb_top;
  import tape_panel_pkg::*;
  logic        clock_i, sys_rst_i, mains, ring, chk, thr_ok, sel, wr, rdst, irq, pwr;
  logic        lower, close, saw_lower, saw_close, thr_q, rst_q, wind;
  logic [6:0]  touch;
  logic [1:0]  addr;
  logic [31:0] wdata, rdata, rd;
  motion_s     motion;
  lamps_s      lamps;
  sensors_s    sens;
  int          n_mismatch, total_checks, n_thread, flips;
  tape_unit_panel_load_control #(.THREAD_CYC(50), .SEARCH_CYC(20), .FLASH_CYC(4),
    .BOUNCE_CYC(3)) tape_unit_panel_load_control_i (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .touch_i(touch), .sensors_i(sens),
    .formatter_controller_select_i(sel), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(wr), .reg_read_i(rdst), .reg_rdata_o(rdata), .irq_o(irq),
    .motion_o(motion), .lamps_o(lamps), .unit_power_o(pwr), .window_lower_o(lower),
    .window_close_o(close));
  tape_transport_model tape_transport_model_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .motion_i(motion), .mains_i(mains), .ring_i(ring), .check_i(chk),
    .thread_ok_i(thr_ok), .wind_i(wind), .sensors_o(sens));
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end
  // pulses are caught here so tasks need not sit on the exact cycle
  always @(posedge clock_i) begin
    thr_q <= motion.thread;
    rst_q <= lamps.reset;
    if (lower === 1'b1) saw_lower <= 1'b1;
    if (close === 1'b1) saw_close <= 1'b1;
    if (motion.thread === 1'b1 && thr_q !== 1'b1) n_thread <= n_thread + 1;
    if (lamps.reset !== rst_q) flips <= flips + 1;
  end
  task automatic cmp(string name, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic press(int b);
    @(posedge clock_i) touch[b] <= 1'b1;
    repeat (10) @(posedge clock_i);
    touch[b] <= 1'b0;
    repeat (14) @(posedge clock_i);
    #1;
  endtask
  task automatic reg_wr(logic [1:0] a, logic [31:0] d);
    @(posedge clock_i) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clock_i) wr <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic reg_rd(logic [1:0] a);
    @(posedge clock_i) {addr, rdst} <= {a, 1'b1};
    @(posedge clock_i) rdst <= 1'b0;
    #1 rd = rdata;
  endtask
  task automatic wait_st(load_state_e s, int n);
    for (int i = 0; i < n; i++) begin
      reg_rd(ADDR_STATE);
      if (rd[15:8] === 8'(s)) break;
    end
    cmp("state", 32'(s), 32'(rd[15:8]));
  endtask
  task automatic t_power();
    press(CTL_POWER);
    cmp("power off", 0, 32'(pwr));
    mains <= 1'b1;
    press(CTL_POWER);
    cmp("power on", 1, 32'(pwr));
    cmp("power lamp", 1, 32'(lamps.power));
  endtask
  task automatic t_density();
    reg_rd(ADDR_STATE);
    cmp("density", 0, 32'(rd[1]));
    for (int i = 1; i <= 2; i++) begin
      press(CTL_DENSITY);
      cmp("group lamp", 32'(i % 2), 32'(lamps.group_density_indicator));
      cmp("phase lamp", 32'(1 - i % 2), 32'(lamps.phase_encoded_density));
    end
  endtask
  task automatic t_load();
    reg_wr(ADDR_ENABLE, 32'h0000001F);
    saw_lower <= 1'b0;
    press(CTL_WINDOW);
    cmp("lower idle", 1, 32'(saw_lower));
    saw_close <= 1'b0;
    press(CTL_LOAD_REWIND);
    wait_st(READY, 80);
    cmp("closed", 1, 32'(saw_close));
    cmp("load lamp", 1, 32'(lamps.load_rewind));
    cmp("protect", 1, 32'(lamps.write_protect));
    cmp("sel lamp", 1, 32'(lamps.rewind_unload));
    reg_rd(ADDR_STATUS);
    cmp("load done", 1, 32'(rd[EVT_LOAD_DONE]));
    cmp("irq", 1, 32'(irq));
    saw_lower <= 1'b0;
    press(CTL_WINDOW);
    cmp("lower loaded", 0, 32'(saw_lower));
    press(CTL_ONLINE);
    cmp("online", 1, 32'(lamps.online));
    press(CTL_REWIND_UNLOAD);
    wait_st(READY, 1);
    press(CTL_RESET);
    cmp("offline", 0, 32'(lamps.online));
    cmp("still", 0, 32'({motion.fwd, motion.rev, motion.high_speed, motion.thread}));
    reg_wr(ADDR_CLEAR, 32'h0000001F);
    cmp("irq clr", 0, 32'(irq));
  endtask
  task automatic t_rewind();
    @(posedge clock_i) wind <= 1'b1;
    @(posedge clock_i) wind <= 1'b0;
    repeat (6) @(posedge clock_i);
    #1;
    cmp("end lamp", 1, 32'(lamps.load_rewind));
    press(CTL_LOAD_REWIND);
    cmp("rew fast", 3, 32'({motion.rev, motion.high_speed}));
    press(CTL_RESET);
    cmp("rew slow", 2, 32'({motion.rev, motion.high_speed}));
    press(CTL_RESET);
    cmp("rew stop", 0, 32'({motion.fwd, motion.rev, motion.high_speed}));
    wait_st(READY, 1);
    press(CTL_REWIND_UNLOAD);
    cmp("unl fast", 3, 32'({motion.rev, motion.high_speed}));
    wait_st(IDLE, 200);
    press(CTL_LOAD_REWIND);
    wait_st(READY, 80);
    reg_wr(ADDR_CLEAR, 32'h0000001F);
  endtask
  task automatic t_unload();
    press(CTL_REWIND_UNLOAD);
    wait_st(IDLE, 80);
    cmp("protect off", 0, 32'(lamps.write_protect));
    reg_rd(ADDR_STATUS);
    cmp("unload done", 1, 32'(rd[EVT_UNLOAD_DONE]));
    cmp("irq set", 1, 32'(irq));
    reg_wr(ADDR_ENABLE, 32'h0);
    cmp("irq mask", 0, 32'(irq));
    reg_wr(ADDR_CLEAR, 32'h0000001F);
    reg_rd(ADDR_STATUS);
    cmp("status clr", 0, rd);
    reg_rd(ADDR_CLEAR);
    cmp("clear wo", 0, rd);
  endtask
  task automatic t_thread_fail();
    thr_ok <= 1'b0;
    n_thread <= 0;
    press(CTL_LOAD_REWIND);
    wait_st(FAILED, 150);
    cmp("attempts", 2, 32'(n_thread));
    flips <= 0;
    repeat (20) @(posedge clock_i);
    cmp("fail flash", 1, 32'(flips >= 2));
    reg_rd(ADDR_STATUS);
    cmp("thread fail", 1, 32'(rd[EVT_THREAD_FAIL]));
    press(CTL_RESET);
    reg_rd(ADDR_STATE);
    cmp("left fail", 1, 32'(rd[15:8] !== 8'(FAILED)));
    thr_ok <= 1'b1;
  endtask
  task automatic t_check();
    chk <= 1'b1;
    flips <= 0;
    repeat (30) @(posedge clock_i);
    cmp("check flash", 1, 32'(flips >= 3));
    reg_rd(ADDR_STATUS);
    cmp("check evt", 1, 32'(rd[EVT_MACHINE_CHECK]));
    chk <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clock_i);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {touch, mains, ring, chk, wr, rdst, addr, wdata, wind} = '0;
    {thr_ok, sel, sys_rst_i} = 3'b111;
    {saw_lower, saw_close, thr_q, rst_q, n_thread, flips} = '0;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    t_power();
    t_density();
    t_load();
    t_rewind();
    t_unload();
    t_thread_fail();
    t_check();
    print_verdict();
  end
endmodule
`default_nettype wire
